// ---- design/rpc_pkg.sv ----
// Constants for the reset and low-power controller
package rpc_pkg;
   // Reset values of the core state
   localparam logic [13:0] PC_RESET      = 14'h0000;
   localparam logic [9:0]  SP_RESET      = 10'h3ff;
   localparam logic        STATUS_RESET  = 1'h1;
   localparam logic        GIE_RESET     = 1'h0;
   localparam logic        IMASK_RESET   = 1'h1;
   localparam logic        IREQ_RESET    = 1'h0;
   localparam logic        STD_LATCH_RST = 1'h1;
   localparam logic        HV_LATCH_RST  = 1'h0;
   localparam logic [3:0]  MODE4_RESET   = 4'h0;
   localparam logic [2:0]  MODE3_RESET   = 3'h0;
   localparam logic [10:0] PRESC_RESET   = 11'h000;
   localparam logic [7:0]  CNT8_RESET    = 8'h00;
   localparam logic [2:0]  OCT_RESET     = 3'h0;
   // APB register offsets (byte addresses)
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_STATUS    = 8'h04;
   localparam logic [7:0]  OFS_CORE      = 8'h08;
   localparam logic [7:0]  OFS_MODES     = 8'h0c;
   localparam logic [7:0]  OFS_COUNTS    = 8'h10;
   localparam logic [7:0]  OFS_IRQ       = 8'h14;
   // Control register field positions
   localparam int          CTRL_SBY_BIT  = 0;
   localparam int          CTRL_STOP_BIT = 1;
   localparam int          CTRL_GIE_BIT  = 2;
   // Cycle counts: one instruction cycle in pclk cycles
   localparam int          INSTR_CYCLE_NS = 40;
   localparam int          CLK_NS         = 10;
   localparam int          INSTR_CYCLES   = (INSTR_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   // Power mode encoding
   typedef enum logic [1:0] {
      RPC_ACTIVE  = 2'b00,
      RPC_STANDBY = 2'b01,
      RPC_STOP    = 2'b10
   } rpc_mode_e;
endpackage

// ---- design/rpc_ctrl.sv ----
// Reset and low-power mode controller of a small 4-bit controller core
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Reset pin high puts and holds the device in reset.
// - Reset clears program counter and loads stack pointer with its top.
// - Reset sets the branch status flag to one.
// - Reset sets standard pin latches to one, high-voltage latches to zero.
// - Reset clears enable and request flags and sets every mask bit.
// - Reset clears port, serial and timer mode registers.
// - Reset clears prescaler, timer counters, reload and octal counter.
// - Working registers and serial data are not preserved over reset.
// - RAM keeps contents across a stop-mode reset only.
// - Standby stops only instruction clock; everything else runs.
// - Standby ends on reset or any interrupt request.
// - Interrupt wake resumes at the instruction after standby.
// - After wake, service the interrupt only if global enable is one.
// - Stop halts oscillator and all functions, keeping RAM.
// - Only reset leaves stop mode; interrupts do not.
// - Leaving stop through reset restores all reset values.
// - In stop the halt indication is active and pins float.
module rpc_ctrl #(
   parameter int N_STD = 32,
   parameter int N_HV  = 26,
   parameter int N_IRQ = 4
) (
   // APB clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // External reset pin, active high, asynchronous to pclk
   input  wire logic               reset_pin,
   // Interrupt request sources, one-cycle pulses on pclk
   input  wire logic [N_IRQ-1:0]   irq_src,
   // Core control
   output logic                    core_reset,
   output logic                    instr_clk_en,
   output logic                    osc_run,
   output logic                    periph_run,
   output logic                    irq_take,
   output logic                    ram_valid,
   output logic                    halt_indication,
   // Pin output latches and enables (enable low drives the pin)
   output logic [N_STD-1:0]        std_latch,
   output logic [N_HV-1:0]         hv_latch,
   output logic                    pin_oe_n
);
   // Elaboration check of the port and interrupt counts
   if (N_STD < 1 || N_STD > 32 || N_HV < 1 || N_HV > 32 || N_IRQ < 1 || N_IRQ > 8) begin : g_bad
      $error("rpc_ctrl: unsupported port or interrupt count");
   end

   // Reset pin synchroniser
   logic rst_meta;
   logic rst_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_meta <= 1'b1;
         rst_sync <= 1'b1;
      end else begin
         rst_meta <= reset_pin;
         rst_sync <= rst_meta;
      end
   end

   // Core state held by this block
   rpc_pkg::rpc_mode_e mode;
   rpc_pkg::rpc_mode_e next_mode;
   logic [13:0]        pc;
   logic [9:0]         stack_pointer_reg;
   logic               branch_status_flag;
   logic               gie;
   logic [N_IRQ-1:0]   irq_req;
   logic [N_IRQ-1:0]   interrupt_mask_bits;
   logic [3:0]         port_mode_reg;
   logic [3:0]         serial_mode_reg;
   logic [2:0]         first_timer_mode_reg;
   logic [3:0]         second_timer_mode_reg;
   logic [10:0]        prescaler;
   logic [7:0]         first_timer_counter;
   logic [7:0]         event_counter;
   logic [7:0]         reload_register;
   logic [2:0]         octal_counter;
   logic               stop_entered;

   // APB decode
   wire        wr_en    = psel && penable && pwrite;
   wire        rd_en    = psel && penable && !pwrite;
   wire        hit_ctrl = paddr == rpc_pkg::OFS_CTRL;
   wire        hit_mode = paddr == rpc_pkg::OFS_MODES;
   wire        hit_cnt  = paddr == rpc_pkg::OFS_COUNTS;
   wire        hit_irq  = paddr == rpc_pkg::OFS_IRQ;
   wire        mapped   = hit_ctrl || hit_mode || hit_cnt || hit_irq
                          || paddr == rpc_pkg::OFS_STATUS || paddr == rpc_pkg::OFS_CORE;
   wire        in_reset = rst_sync;
   wire        active   = mode == rpc_pkg::RPC_ACTIVE;
   wire        running  = mode != rpc_pkg::RPC_STOP;
   wire        sby_cmd  = wr_en && hit_ctrl && pwdata[rpc_pkg::CTRL_SBY_BIT] && active;
   wire        stop_cmd = wr_en && hit_ctrl && pwdata[rpc_pkg::CTRL_STOP_BIT] && active;
   wire        any_req  = |(irq_req | (running ? irq_src : '0));
   wire [N_IRQ-1:0] pend = irq_req & ~interrupt_mask_bits;
   wire        prs_tick = prescaler == 11'h7ff;

   // Power mode transitions
   always_comb begin
      next_mode = mode;
      unique case (mode)
         rpc_pkg::RPC_ACTIVE: begin
            if (stop_cmd) begin
               next_mode = rpc_pkg::RPC_STOP;
            end else if (sby_cmd) begin
               next_mode = rpc_pkg::RPC_STANDBY;
            end
         end
         rpc_pkg::RPC_STANDBY: begin
            if (any_req) begin
               next_mode = rpc_pkg::RPC_ACTIVE;
            end
         end
         rpc_pkg::RPC_STOP: begin
            next_mode = rpc_pkg::RPC_STOP;
         end
         default: next_mode = rpc_pkg::RPC_ACTIVE;
      endcase
   end

   // Mode register; reset wins over every mode, stop included
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= rpc_pkg::RPC_ACTIVE;
      end else if (in_reset) begin
         mode <= rpc_pkg::RPC_ACTIVE;
      end else begin
         mode <= next_mode;
      end
   end

   // Core registers loaded with reset values while reset is held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc                 <= rpc_pkg::PC_RESET;
         stack_pointer_reg  <= rpc_pkg::SP_RESET;
         branch_status_flag <= rpc_pkg::STATUS_RESET;
         gie                <= rpc_pkg::GIE_RESET;
      end else if (in_reset) begin
         pc                 <= rpc_pkg::PC_RESET;
         stack_pointer_reg  <= rpc_pkg::SP_RESET;
         branch_status_flag <= rpc_pkg::STATUS_RESET;
         gie                <= rpc_pkg::GIE_RESET;
      end else begin
         if (active) begin
            pc <= pc + 14'h0001;
         end
         if (wr_en && hit_ctrl && active) begin
            gie <= pwdata[rpc_pkg::CTRL_GIE_BIT];
         end
      end
   end

   // Interrupt flags and masks; a new request wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req             <= {N_IRQ{rpc_pkg::IREQ_RESET}};
         interrupt_mask_bits <= {N_IRQ{rpc_pkg::IMASK_RESET}};
      end else if (in_reset) begin
         irq_req             <= {N_IRQ{rpc_pkg::IREQ_RESET}};
         interrupt_mask_bits <= {N_IRQ{rpc_pkg::IMASK_RESET}};
      end else begin
         irq_req <= (irq_req & ~((wr_en && hit_irq) ? pwdata[N_IRQ-1:0] : '0))
                    | (running ? irq_src : '0);
         if (wr_en && hit_irq) begin
            interrupt_mask_bits <= pwdata[N_IRQ+7:8];
         end
      end
   end

   // Mode registers of ports, serial and timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_mode_reg         <= rpc_pkg::MODE4_RESET;
         serial_mode_reg       <= rpc_pkg::MODE4_RESET;
         first_timer_mode_reg  <= rpc_pkg::MODE3_RESET;
         second_timer_mode_reg <= rpc_pkg::MODE4_RESET;
      end else if (in_reset) begin
         port_mode_reg         <= rpc_pkg::MODE4_RESET;
         serial_mode_reg       <= rpc_pkg::MODE4_RESET;
         first_timer_mode_reg  <= rpc_pkg::MODE3_RESET;
         second_timer_mode_reg <= rpc_pkg::MODE4_RESET;
      end else if (wr_en && hit_mode) begin
         port_mode_reg         <= pwdata[3:0];
         serial_mode_reg       <= pwdata[7:4];
         first_timer_mode_reg  <= pwdata[10:8];
         second_timer_mode_reg <= pwdata[15:12];
      end
   end

   // Prescaler and counters keep running in standby, freeze in stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescaler           <= rpc_pkg::PRESC_RESET;
         first_timer_counter <= rpc_pkg::CNT8_RESET;
         event_counter       <= rpc_pkg::CNT8_RESET;
         reload_register     <= rpc_pkg::CNT8_RESET;
         octal_counter       <= rpc_pkg::OCT_RESET;
      end else if (in_reset) begin
         prescaler           <= rpc_pkg::PRESC_RESET;
         first_timer_counter <= rpc_pkg::CNT8_RESET;
         event_counter       <= rpc_pkg::CNT8_RESET;
         reload_register     <= rpc_pkg::CNT8_RESET;
         octal_counter       <= rpc_pkg::OCT_RESET;
      end else if (running) begin
         prescaler <= prescaler + 11'h001;
         if (prs_tick) begin
            first_timer_counter <= first_timer_counter + 8'h01;
            event_counter       <= event_counter + 8'h01;
            octal_counter       <= octal_counter + 3'h1;
         end
         if (wr_en && hit_cnt) begin
            reload_register <= pwdata[7:0];
         end
      end
   end

   // Stop marker decides whether RAM survives the next reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_entered <= 1'b0;
         ram_valid    <= 1'b0;
      end else begin
         if (mode == rpc_pkg::RPC_STOP) begin
            stop_entered <= 1'b1;
         end else if (!in_reset) begin
            stop_entered <= 1'b0;
         end
         // Held until the next reset, so software can tell a stop wake-up apart
         if (in_reset) begin
            ram_valid <= stop_entered;
         end
      end
   end

   // Registered outputs toward the core and pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_reset      <= 1'b1;
         instr_clk_en    <= 1'b0;
         osc_run         <= 1'b1;
         periph_run      <= 1'b0;
         irq_take        <= 1'b0;
         halt_indication <= 1'b0;
         pin_oe_n        <= 1'b0;
         std_latch       <= {N_STD{rpc_pkg::STD_LATCH_RST}};
         hv_latch        <= {N_HV{rpc_pkg::HV_LATCH_RST}};
      end else begin
         core_reset      <= in_reset;
         instr_clk_en    <= !in_reset && next_mode == rpc_pkg::RPC_ACTIVE;
         osc_run         <= in_reset || next_mode != rpc_pkg::RPC_STOP;
         periph_run      <= !in_reset && next_mode != rpc_pkg::RPC_STOP;
         irq_take        <= !in_reset && active && gie && (|pend);
         halt_indication <= !in_reset && next_mode == rpc_pkg::RPC_STOP;
         pin_oe_n        <= !in_reset && next_mode == rpc_pkg::RPC_STOP;
         if (in_reset) begin
            std_latch <= {N_STD{rpc_pkg::STD_LATCH_RST}};
            hv_latch  <= {N_HV{rpc_pkg::HV_LATCH_RST}};
         end
      end
   end

   // APB read mux and answer
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[rpc_pkg::CTRL_GIE_BIT] = gie;
      end else if (paddr == rpc_pkg::OFS_STATUS) begin
         rd_mux[3:0] = {ram_valid, branch_status_flag, mode};
      end else if (paddr == rpc_pkg::OFS_CORE) begin
         rd_mux[29:0] = {stack_pointer_reg, 2'h0, pc, 4'h0};
      end else if (hit_mode) begin
         rd_mux[15:0] = {second_timer_mode_reg, 1'b0, first_timer_mode_reg,
                         serial_mode_reg, port_mode_reg};
      end else if (hit_cnt) begin
         rd_mux[31:0] = {octal_counter, prescaler[9:0], 3'h0,
                         event_counter, first_timer_counter};
      end else if (hit_irq) begin
         rd_mux[N_IRQ-1:0]  = irq_req;
         rd_mux[N_IRQ+7:8]  = interrupt_mask_bits;
      end
   end

   // Zero-wait APB answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   // Checks
   stop_no_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == rpc_pkg::RPC_STOP && !in_reset) |=> mode == rpc_pkg::RPC_STOP)
      else $error("stop left without reset");
   reset_pc_a: assert property (@(posedge pclk) disable iff (!presetn)
      in_reset |=> pc == rpc_pkg::PC_RESET && stack_pointer_reg == rpc_pkg::SP_RESET)
      else $error("pc or sp not reset");
   reset_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
      in_reset |=> branch_status_flag && !gie && irq_req == '0 && &interrupt_mask_bits)
      else $error("flags not reset");
   reset_core_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(in_reset) |=> core_reset [*1])
      else $error("core reset not raised");
   standby_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == rpc_pkg::RPC_STANDBY && !in_reset && |irq_src) |=> active)
      else $error("standby not woken");
   standby_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == rpc_pkg::RPC_STANDBY && !in_reset) |=> !instr_clk_en || active)
      else $error("instruction clock runs in standby");
   stop_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == rpc_pkg::RPC_STOP && !in_reset) |-> halt_indication && pin_oe_n && !osc_run)
      else $error("halt outputs wrong in stop");
   stop_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == rpc_pkg::RPC_STOP && $past(mode) == rpc_pkg::RPC_STOP && !in_reset)
      |-> $stable(prescaler))
      else $error("prescaler runs in stop");
   reset_modes_a: assert property (@(posedge pclk) disable iff (!presetn)
      in_reset |=> port_mode_reg == 4'h0 && first_timer_mode_reg == 3'h0 && prescaler == 11'h000)
      else $error("mode or prescaler not cleared");
endmodule

// ---- tb/rpc_supervisor.sv ----
// Model of the external reset source that sits beside the controller
`timescale 1ns/1ps
module rpc_supervisor #(
   parameter int MIN_HOLD = 8,
   parameter int SETTLE   = 40
) (
   // Clock and oscillator state seen from outside
   input  wire logic pclk,
   input  wire logic osc_run,
   // Bench request and reset pin
   input  wire logic req,
   output logic      reset_pin
);
   logic [7:0] cnt;
   logic       need_long;

   // Power-on starts with the pin high for the full settling time
   initial begin
      reset_pin = 1'b1;
      cnt       = 8'h00;
      need_long = 1'b1;
   end

   // Hold the pin at least the minimum, longer when the oscillator was stopped
   always @(posedge pclk) begin
      if (reset_pin) begin
         cnt <= cnt + 8'h01;
         if (!req && cnt >= (need_long ? SETTLE : MIN_HOLD)) begin
            reset_pin <= 1'b0;
         end
      end else if (req) begin
         reset_pin <= 1'b1;
         cnt       <= 8'h01;
         need_long <= !osc_run;
      end
   end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the reset and low-power controller
`timescale 1ns/1ps
module testbench;
   typedef struct {
      logic [31:0] val;
      logic [31:0] mask;
      logic        err;
   } rpc_note_s;
   // Clock, reset and bus
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   // Pins and core controls
   logic        reset_pin;
   logic        rst_req;
   logic [3:0]  irq_src;
   logic        core_reset;
   logic        instr_clk_en;
   logic        osc_run;
   logic        periph_run;
   logic        irq_take;
   logic        ram_valid;
   logic        halt_indication;
   logic [31:0] std_latch;
   logic [25:0] hv_latch;
   logic        pin_oe_n;
   // Bookkeeping
   int          bad_count;
   int          n_checks;
   int          cycles;
   int          k;
   logic [31:0] rnd;
   rpc_note_s   notes[$];
   rpc_note_s   head;

   rpc_ctrl rpc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_pin(reset_pin), .irq_src(irq_src), .core_reset(core_reset),
      .instr_clk_en(instr_clk_en), .osc_run(osc_run), .periph_run(periph_run),
      .irq_take(irq_take), .ram_valid(ram_valid), .halt_indication(halt_indication),
      .std_latch(std_latch), .hv_latch(hv_latch), .pin_oe_n(pin_oe_n));

   rpc_supervisor rpc_supervisor_i (.pclk(pclk), .osc_run(osc_run), .req(rst_req),
      .reset_pin(reset_pin));

   // Free-running 100 MHz clock
   always #5 pclk = ~pclk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test;
      if (bad_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Lets registered outputs settle before they are compared
   task automatic settle;
      @(negedge pclk);
   endtask

   // One APB transfer; the expected answer is queued for the monitor
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic [31:0] m, input logic err);
      @(posedge pclk);
      notes.push_back('{exp, m, err});
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic pulse_irq;
      @(posedge pclk);
      irq_src <= 4'h1 << k;
      @(posedge pclk);
      irq_src <= 4'h0;
      repeat (3) @(posedge pclk);
   endtask

   // Compares each finished transfer with the oldest queued note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
         head = notes.pop_front();
         check("prdata", prdata & head.mask, head.val & head.mask);
         check("pslverr", {31'h0, pslverr}, {31'h0, head.err});
      end
   end

   // Cuts a hang short
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         end_of_test();
      end
   end

   // Main sequence
   initial begin
      void'($urandom(64969));
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rst_req = 1'b0;
      irq_src = 4'h0;
      bad_count = 0;
      n_checks = 0;
      cycles = 0;
      k = $urandom % 4;
      rnd = $urandom | 32'h0000_0001;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      while (core_reset !== 1'b0) @(posedge pclk);
      // Move modes, enable and masks off their reset values first
      apb(1, rpc_pkg::OFS_MODES, rnd, 32'h0, 32'h0, 0);
      apb(0, rpc_pkg::OFS_MODES, 0, rnd, 32'hf7ff, 0);
      apb(1, rpc_pkg::OFS_IRQ, 32'h0, 32'h0, 32'h0, 0);
      apb(1, rpc_pkg::OFS_CTRL, 32'h4, 32'h0, 32'h0, 0);
      apb(0, rpc_pkg::OFS_CTRL, 0, 32'h4, 32'h4, 0);
      // Pin reset: registers read while the pin is still held
      rst_req <= 1'b1;
      while (core_reset !== 1'b1) @(posedge pclk);
      apb(0, rpc_pkg::OFS_CORE, 0, 32'h3ff00000, 32'h3ff3fff0, 0);
      apb(0, rpc_pkg::OFS_STATUS, 0, 32'h4, 32'h4, 0);
      apb(0, rpc_pkg::OFS_IRQ, 0, 32'hf00, 32'hf0f, 0);
      apb(0, rpc_pkg::OFS_CTRL, 0, 32'h0, 32'h4, 0);
      apb(0, rpc_pkg::OFS_MODES, 0, 32'h0, 32'hf7ff, 0);
      apb(0, rpc_pkg::OFS_COUNTS, 0, 32'h0, 32'hfff8ffff, 0);
      settle();
      check("core_reset", {31'h0, core_reset}, 32'h1);
      check("std_latch", std_latch, 32'hffffffff);
      check("hv_latch", {6'h0, hv_latch}, 32'h0);
      rst_req <= 1'b0;
      while (core_reset !== 1'b0) @(posedge pclk);
      apb(0, rpc_pkg::OFS_STATUS, 0, 32'h4, 32'hf, 0);
      settle();
      check("ram_valid", {31'h0, ram_valid}, 32'h0);
      // Unmapped places answer with an error
      apb(0, 8'h18, 0, 32'h0, 32'hffffffff, 1);
      apb(1, 8'h1c, 32'hffffffff, 32'h0, 32'h0, 1);
      // Standby, then wake by a request while interrupts are disabled
      apb(1, rpc_pkg::OFS_CTRL, 32'h1, 32'h0, 32'h0, 0);
      settle();
      check("instr_clk_en", {31'h0, instr_clk_en}, 32'h0);
      check("osc_periph", {30'h0, osc_run, periph_run}, 32'h3);
      apb(0, rpc_pkg::OFS_STATUS, 0, 32'h1, 32'h3, 0);
      pulse_irq();
      settle();
      check("instr_clk_en", {31'h0, instr_clk_en}, 32'h1);
      check("irq_take", {31'h0, irq_take}, 32'h0);
      apb(0, rpc_pkg::OFS_IRQ, 0, 32'h1 << k, 32'hf, 0);
      apb(1, rpc_pkg::OFS_IRQ, 32'h0, 32'h0, 32'h0, 0);
      apb(1, rpc_pkg::OFS_CTRL, 32'h4, 32'h0, 32'h0, 0);
      settle();
      check("irq_take", {31'h0, irq_take}, 32'h1);
      apb(1, rpc_pkg::OFS_IRQ, 32'hf, 32'h0, 32'h0, 0);
      apb(1, rpc_pkg::OFS_CTRL, 32'h0, 32'h0, 32'h0, 0);
      settle();
      check("irq_take", {31'h0, irq_take}, 32'h0);
      // Stop: requests are ignored, only the pin brings it back
      apb(1, rpc_pkg::OFS_CTRL, 32'h2, 32'h0, 32'h0, 0);
      settle();
      check("osc_periph", {30'h0, osc_run, periph_run}, 32'h0);
      check("halt_oe", {30'h0, halt_indication, pin_oe_n}, 32'h3);
      pulse_irq();
      settle();
      check("halt_clk", {30'h0, halt_indication, instr_clk_en}, 32'h2);
      apb(0, rpc_pkg::OFS_STATUS, 0, 32'h2, 32'h3, 0);
      rst_req <= 1'b1;
      while (core_reset !== 1'b1) @(posedge pclk);
      settle();
      check("osc_clk", {30'h0, osc_run, instr_clk_en}, 32'h2);
      rst_req <= 1'b0;
      while (core_reset !== 1'b0) @(posedge pclk);
      apb(0, rpc_pkg::OFS_STATUS, 0, 32'hc, 32'hf, 0);
      apb(0, rpc_pkg::OFS_IRQ, 0, 32'hf00, 32'hf0f, 0);
      apb(0, rpc_pkg::OFS_CORE, 0, 32'h3ff00000, 32'h3ff00000, 0);
      settle();
      check("halt_oe", {30'h0, halt_indication, pin_oe_n}, 32'h0);
      check("std_latch", std_latch, 32'hffffffff);
      check("ram_valid", {31'h0, ram_valid}, 32'h1);
      repeat (2) @(posedge pclk);
      end_of_test();
   end
endmodule
